// File: rtl/rlw_pkg.sv
// Package with register map, field positions and reset values of the regulator control block.
package rlw_pkg;

  // ------------------------------------------------------------
  // Register indices; byte address is four times the index.
  // ------------------------------------------------------------
  localparam logic [9:0] IDX_LV_CTRL = 10'h2f1;
  localparam logic [9:0] IDX_APIC = 10'h2f2;
  localparam logic [9:0] IDX_TRIM = 10'h2f3;
  localparam logic [9:0] IDX_RATE_HI = 10'h2f4;
  localparam logic [9:0] IDX_RATE_LO = 10'h2f5;

  // ------------------------------------------------------------
  // Field positions inside the byte registers.
  // ------------------------------------------------------------
  localparam int LV_STATUS_BIT = 2;
  localparam int LV_IRQEN_BIT = 1;
  localparam int LV_FLAG_BIT = 0;
  localparam int AP_CLKSEL_BIT = 7;
  localparam int AP_WAVE_BIT = 4;
  localparam int AP_OUTEN_BIT = 3;
  localparam int AP_FEAT_BIT = 2;
  localparam int AP_IRQEN_BIT = 1;
  localparam int AP_FLAG_BIT = 0;
  localparam int TRIM_MSB = 7;
  localparam int TRIM_LSB = 2;

  // ------------------------------------------------------------
  // Values after reset.
  // ------------------------------------------------------------
  localparam logic [5:0] TRIM_RESET = 6'h00;
  localparam logic [15:0] RATE_RESET = 16'h0000;
  localparam logic LV_IRQEN_RESET = 1'b0;

  // ------------------------------------------------------------
  // Bus response codes.
  // ------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------
  // Periodic timer control fields that software writes.
  // ------------------------------------------------------------
  typedef struct packed {
    logic clkSel;
    logic waveSel;
    logic outEn;
    logic featEn;
    logic irqEn;
  } rlw_apic_s;

  localparam rlw_apic_s APIC_RESET = 5'h00;

endpackage : rlw_pkg

// File: rtl/rlw_tick_gen.sv
// Periodic timer counter that marks the end of each configured period.
module rlw_tick_gen (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Control from the register file.
  input wire logic enable,
  input wire logic tick,
  input wire logic [15:0] rate,
  // One-cycle mark at each period end.
  output logic periodEnd
);

  logic [16:0] count_reg;
  logic periodEnd_reg;
  logic [16:0] terminal;

  // A period is 2*(rate+1) ticks, so the last count is 2*rate+1.
  assign terminal = {rate, 1'b1};

  // The counter restarts from zero whenever the function is disabled.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count_reg <= 17'h00000;
      periodEnd_reg <= 1'b0;
    end else if (!enable) begin
      count_reg <= 17'h00000;
      periodEnd_reg <= 1'b0;
    end else begin
      periodEnd_reg <= 1'b0;
      if (tick) begin
        if (count_reg == terminal) begin
          count_reg <= 17'h00000;
          periodEnd_reg <= 1'b1;
        end else begin
          count_reg <= count_reg + 17'h00001;
        end
      end
    end
  end

  assign periodEnd = periodEnd_reg;

endmodule : rlw_tick_gen

// File: rtl/rlw_regulator_lvd_periodic_wakeup.sv
// Regulator control logic: low-voltage detect status and the periodic wakeup timer.
//
// Summary of operation
// - Low-voltage status is read-only, follows the comparator; writes leave it alone.
// - Status reads 1 only below threshold in full performance; otherwise 0.
// - Any change of low-voltage status sets the low-voltage change flag.
// - Change flag clears only by writing 1; writing 0 does nothing.
// - Low-voltage interrupt requested while change flag and its enable are both set.
// - Entering reduced power keeps the change flag until software clears it.
// - Clock select 0 counts oscillator ticks, 1 counts bus clock cycles.
// - Clock select writable only while disabled and not enabled by same write.
// - Waveform select picks a toggling clock or a short pulse per period.
// - External waveform driven only with output enable and feature enable set.
// - Feature enable starts the timer; clearing it stops the function.
// - Timeout flag sets each time the configured period elapses.
// - Timeout flag clears by writing 1; a clear beats a coincident timeout.
// - Periodic interrupt requested while timeout flag and its enable are set.
// - Six-bit trim in bits seven to two adjusts the oscillator period.
// - Trim field resets to zero or to a configured factory value.
// - Period is two times (rate plus one), times tick or bus period.
// - Rate value writable only while the feature enable is clear.
// - Low-voltage detection works only in full performance mode.
module rlw_regulator_lvd_periodic_wakeup #(
  parameter logic [5:0] TRIM_RESET = rlw_pkg::TRIM_RESET
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // AXI4-Lite write address channel.
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address channel.
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog side inputs, asynchronous to sys_clk.
  input wire logic supplyLowRaw,
  input wire logic fullPerfRaw,
  input wire logic autoOscRaw,
  // Analog trim and external waveform pin.
  output logic [5:0] periodTrim,
  output logic wakeupOut,
  output logic wakeupOutEn,
  // Interrupt requests.
  output logic lowVoltageIrq,
  output logic wakeupIrq
);

  // ------------------------------------------------------------
  // Declarations.
  // ------------------------------------------------------------
  logic cmpMeta_reg, cmpSync_reg;
  logic fpmMeta_reg, fpmSync_reg;
  logic oscMeta_reg, oscSync_reg, oscPrev_reg;
  logic awready_reg, wready_reg, bvalid_reg;
  logic awDone_reg, wDone_reg;
  logic [11:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic [1:0] bresp_reg;
  logic arready_reg, rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic lvIrqEn_reg;
  rlw_pkg::rlw_apic_s apic_reg;
  logic [5:0] trim_reg;
  logic [15:0] rate_reg;
  logic lvdStatus_reg, lvFlag_reg, wakeFlag_reg;
  logic toggle_reg, pulse_reg;
  logic wakeupOut_reg, wakeupOutEn_reg;
  logic lvIrq_reg, wakeIrq_reg;
  logic doWrite, writeHit;
  logic wrLv, wrApic, wrTrim, wrRateHi, wrRateLo;
  logic [7:0] wByte;
  logic lvdNext, oscTick, timerTick, periodEnd, outGate;
  logic [7:0] rdByte;
  logic rdHit;

  // True when a byte address selects the register with the given index.
  function automatic logic hitIndex(input logic [11:0] addr, input logic [9:0] idx);
    hitIndex = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
  endfunction : hitIndex

  // ------------------------------------------------------------
  // Input synchronisers.
  // ------------------------------------------------------------
  // The analog signals change at any time, so each passes two flops first.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cmpMeta_reg <= 1'b0;
      cmpSync_reg <= 1'b0;
      fpmMeta_reg <= 1'b0;
      fpmSync_reg <= 1'b0;
      oscMeta_reg <= 1'b0;
      oscSync_reg <= 1'b0;
      oscPrev_reg <= 1'b0;
    end else begin
      cmpMeta_reg <= supplyLowRaw;
      cmpSync_reg <= cmpMeta_reg;
      fpmMeta_reg <= fullPerfRaw;
      fpmSync_reg <= fpmMeta_reg;
      oscMeta_reg <= autoOscRaw;
      oscSync_reg <= oscMeta_reg;
      oscPrev_reg <= oscSync_reg;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write side.
  // ------------------------------------------------------------
  // Address and data are taken in either order; the write happens once both are held.
  assign doWrite = awDone_reg & wDone_reg & ~bvalid_reg;
  assign writeHit = hitIndex(awAddr_reg, rlw_pkg::IDX_LV_CTRL)
    | hitIndex(awAddr_reg, rlw_pkg::IDX_APIC)
    | hitIndex(awAddr_reg, rlw_pkg::IDX_TRIM)
    | hitIndex(awAddr_reg, rlw_pkg::IDX_RATE_HI)
    | hitIndex(awAddr_reg, rlw_pkg::IDX_RATE_LO);

  // Only byte lane 0 carries register data; other lanes are ignored.
  assign wByte = wData_reg[7:0];
  assign wrLv = doWrite & wStrb_reg[0] & hitIndex(awAddr_reg, rlw_pkg::IDX_LV_CTRL);
  assign wrApic = doWrite & wStrb_reg[0] & hitIndex(awAddr_reg, rlw_pkg::IDX_APIC);
  assign wrTrim = doWrite & wStrb_reg[0] & hitIndex(awAddr_reg, rlw_pkg::IDX_TRIM);
  assign wrRateHi = doWrite & wStrb_reg[0] & hitIndex(awAddr_reg, rlw_pkg::IDX_RATE_HI);
  assign wrRateLo = doWrite & wStrb_reg[0] & hitIndex(awAddr_reg, rlw_pkg::IDX_RATE_LO);

  // Ready drops after each capture so only one write is in flight at a time.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      awDone_reg <= 1'b0;
      wDone_reg <= 1'b0;
      awAddr_reg <= 12'h000;
      wData_reg <= 32'h00000000;
      wStrb_reg <= 4'h0;
      bresp_reg <= rlw_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        awDone_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        wDone_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite) begin
        awDone_reg <= 1'b0;
        wDone_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= writeHit ? rlw_pkg::RESP_OKAY : rlw_pkg::RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Configuration registers.
  // ------------------------------------------------------------
  // Clock select and rate are locked while the timer runs, so a period never changes mid-count.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lvIrqEn_reg <= rlw_pkg::LV_IRQEN_RESET;
      apic_reg <= rlw_pkg::APIC_RESET;
      trim_reg <= TRIM_RESET;
      rate_reg <= rlw_pkg::RATE_RESET;
    end else begin
      if (wrLv) begin
        lvIrqEn_reg <= wByte[rlw_pkg::LV_IRQEN_BIT];
      end
      if (wrApic) begin
        if (!apic_reg.featEn && !wByte[rlw_pkg::AP_FEAT_BIT]) begin
          apic_reg.clkSel <= wByte[rlw_pkg::AP_CLKSEL_BIT];
        end
        apic_reg.waveSel <= wByte[rlw_pkg::AP_WAVE_BIT];
        apic_reg.outEn <= wByte[rlw_pkg::AP_OUTEN_BIT];
        apic_reg.featEn <= wByte[rlw_pkg::AP_FEAT_BIT];
        apic_reg.irqEn <= wByte[rlw_pkg::AP_IRQEN_BIT];
      end
      if (wrTrim) begin
        trim_reg <= wByte[rlw_pkg::TRIM_MSB:rlw_pkg::TRIM_LSB];
      end
      if (wrRateHi && !apic_reg.featEn) begin
        rate_reg[15:8] <= wByte;
      end
      if (wrRateLo && !apic_reg.featEn) begin
        rate_reg[7:0] <= wByte;
      end
    end
  end

  // ------------------------------------------------------------
  // Low-voltage detect.
  // ------------------------------------------------------------
  // Outside full performance the detector is off and its status reads low.
  assign lvdNext = cmpSync_reg & fpmSync_reg;

  // Status follows the comparator only; no bus write touches it.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lvdStatus_reg <= 1'b0;
    end else begin
      lvdStatus_reg <= lvdNext;
    end
  end

  // A change in either direction sets the flag, and the set beats a clear.
  // No mode change clears it, so the event survives entry into reduced power.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lvFlag_reg <= 1'b0;
    end else if (lvdNext != lvdStatus_reg) begin
      lvFlag_reg <= 1'b1;
    end else if (wrLv && wByte[rlw_pkg::LV_FLAG_BIT]) begin
      lvFlag_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Periodic timer.
  // ------------------------------------------------------------
  // The oscillator is sampled, so its frequency must stay well below sys_clk.
  assign oscTick = oscSync_reg & ~oscPrev_reg;
  assign timerTick = apic_reg.clkSel ? 1'b1 : oscTick;

  rlw_tick_gen u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .enable(apic_reg.featEn),
    .tick(timerTick),
    .rate(rate_reg),
    .periodEnd(periodEnd)
  );

  // Here the clear wins over a coincident timeout, unlike the low-voltage flag.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wakeFlag_reg <= 1'b0;
    end else if (wrApic && wByte[rlw_pkg::AP_FLAG_BIT]) begin
      wakeFlag_reg <= 1'b0;
    end else if (periodEnd) begin
      wakeFlag_reg <= 1'b1;
    end
  end

  // The pulse lasts one tick, which is half the shortest period.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      toggle_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else if (!apic_reg.featEn) begin
      toggle_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else if (periodEnd) begin
      toggle_reg <= ~toggle_reg;
      pulse_reg <= 1'b1;
    end else if (timerTick) begin
      pulse_reg <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Outputs to the pin and interrupt lines.
  // ------------------------------------------------------------
  assign outGate = apic_reg.outEn & apic_reg.featEn;

  // Registered so every output comes straight from a flop, at one cycle of lag.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wakeupOut_reg <= 1'b0;
      wakeupOutEn_reg <= 1'b0;
    end else begin
      wakeupOut_reg <= outGate & (apic_reg.waveSel ? toggle_reg : pulse_reg);
      wakeupOutEn_reg <= outGate;
    end
  end

  // Interrupt requests are levels that follow flag and enable.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lvIrq_reg <= 1'b0;
      wakeIrq_reg <= 1'b0;
    end else begin
      lvIrq_reg <= lvFlag_reg & lvIrqEn_reg;
      wakeIrq_reg <= wakeFlag_reg & apic_reg.irqEn;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read side.
  // ------------------------------------------------------------
  // Read data byte for the addressed register; unmapped reads give zero.
  always_comb begin
    rdByte = 8'h00;
    rdHit = 1'b1;
    if (hitIndex(s_axi_araddr, rlw_pkg::IDX_LV_CTRL)) begin
      rdByte = {5'h00, lvdStatus_reg, lvIrqEn_reg, lvFlag_reg};
    end else if (hitIndex(s_axi_araddr, rlw_pkg::IDX_APIC)) begin
      rdByte = {apic_reg.clkSel, 2'b00, apic_reg.waveSel, apic_reg.outEn,
                apic_reg.featEn, apic_reg.irqEn, wakeFlag_reg};
    end else if (hitIndex(s_axi_araddr, rlw_pkg::IDX_TRIM)) begin
      rdByte = {trim_reg, 2'b00};
    end else if (hitIndex(s_axi_araddr, rlw_pkg::IDX_RATE_HI)) begin
      rdByte = rate_reg[15:8];
    end else if (hitIndex(s_axi_araddr, rlw_pkg::IDX_RATE_LO)) begin
      rdByte = rate_reg[7:0];
    end else begin
      rdHit = 1'b0;
    end
  end

  // One read at a time; the answer appears the cycle after the address is taken.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= rlw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= {24'h000000, rdByte};
      rresp_reg <= rdHit ? rlw_pkg::RESP_OKAY : rlw_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign periodTrim = trim_reg;
  assign wakeupOut = wakeupOut_reg;
  assign wakeupOutEn = wakeupOutEn_reg;
  assign lowVoltageIrq = lvIrq_reg;
  assign wakeupIrq = wakeIrq_reg;

  // ------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // A write that tries to flip the status does not move it.
  AST_LVD_READ_ONLY: assert property (
    (wrLv && (wByte[rlw_pkg::LV_STATUS_BIT] != lvdStatus_reg) && (lvdNext == lvdStatus_reg))
    |=> $stable(lvdStatus_reg))
    else $error("Low-voltage status changed by a bus write.");

  // Without full performance the status reads low one edge after the synchroniser.
  AST_LVD_FPM_ONLY: assert property (
    !fpmSync_reg |=> !lvdStatus_reg)
    else $error("Low-voltage status high outside full performance.");

  // Comparator high (supply low) in full performance shows as status high.
  AST_LVD_ASSERT: assert property (
    (cmpSync_reg && fpmSync_reg) |=> lvdStatus_reg)
    else $error("Low-voltage status missed a low supply.");

  // Every status change leaves the change flag set.
  AST_LV_FLAG_SET: assert property (
    $changed(lvdStatus_reg) |-> lvFlag_reg)
    else $error("Status change did not set the change flag.");

  // The change flag holds unless software writes a one to it.
  AST_LV_FLAG_HOLD: assert property (
    (lvFlag_reg && !(wrLv && wByte[rlw_pkg::LV_FLAG_BIT])) |=> lvFlag_reg)
    else $error("Change flag cleared without a write of one.");

  // Request follows flag and enable; no request with the enable low.
  AST_LV_IRQ: assert property (
    (lvFlag_reg && lvIrqEn_reg) |=> lowVoltageIrq)
    else $error("Low-voltage request missing.");

  AST_LV_IRQ_MASKED: assert property (
    !lvIrqEn_reg |=> !lowVoltageIrq)
    else $error("Low-voltage request raised while disabled.");

  // Clock select stays put while running or when the same write enables.
  AST_CLKSEL_LOCK: assert property (
    (apic_reg.featEn || (wrApic && wByte[rlw_pkg::AP_FEAT_BIT])) |=> $stable(apic_reg.clkSel))
    else $error("Clock select changed while locked.");

  // Rate stays put while the timer runs.
  AST_RATE_LOCK: assert property (
    apic_reg.featEn |=> $stable(rate_reg))
    else $error("Rate value changed while the timer runs.");

  // The pin is released and low whenever either enable is off.
  AST_OUT_GATE: assert property (
    !outGate |=> (!wakeupOut && !wakeupOutEn))
    else $error("Waveform driven while not enabled.");

  // In clock mode the toggle flips at each period end.
  AST_TOGGLE: assert property (
    (periodEnd && apic_reg.featEn) |=> (toggle_reg != $past(toggle_reg)))
    else $error("Waveform toggle missed a period end.");

  // With the function disabled no period end is produced.
  AST_TIMER_STOP: assert property (
    !apic_reg.featEn |=> !periodEnd)
    else $error("Timer ran while disabled.");

  // A timeout sets the flag unless a clearing write meets it.
  AST_WAKE_FLAG_SET: assert property (
    (periodEnd && !(wrApic && wByte[rlw_pkg::AP_FLAG_BIT])) |=> wakeFlag_reg)
    else $error("Timeout did not set the flag.");

  AST_WAKE_CLEAR_WINS: assert property (
    (wrApic && wByte[rlw_pkg::AP_FLAG_BIT]) |=> !wakeFlag_reg)
    else $error("Clearing write lost to a timeout.");

  AST_WAKE_IRQ: assert property (
    (wakeFlag_reg && apic_reg.irqEn) |=> wakeupIrq)
    else $error("Periodic request missing.");

  // Bus clock mode with rate zero gives a period end every second cycle.
  AST_BUS_PERIOD: assert property (
    (periodEnd && apic_reg.clkSel && (rate_reg == 16'h0000) && apic_reg.featEn)
    ##1 apic_reg.featEn |=> periodEnd)
    else $error("Shortest bus clock period is not two cycles.");

endmodule : rlw_regulator_lvd_periodic_wakeup

// File: tb/rlw_regulator_lvd_periodic_wakeup_bench.sv
// Self-checking bench for the regulator control block.
module rlw_regulator_lvd_periodic_wakeup_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b1;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b1;
  logic supplyLowRaw = 1'b0;
  logic fullPerfRaw = 1'b1;
  logic autoOscRaw = 1'b0;
  logic [1:0] oscCnt = 2'h0;
  logic [5:0] periodTrim;
  logic wakeupOut;
  logic wakeupOutEn;
  logic lowVoltageIrq;
  logic wakeupIrq;
  int errorCnt = 0;
  int nTests = 0;

  rlw_regulator_lvd_periodic_wakeup dut_u (.sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .supplyLowRaw(supplyLowRaw),
    .fullPerfRaw(fullPerfRaw), .autoOscRaw(autoOscRaw), .periodTrim(periodTrim),
    .wakeupOut(wakeupOut), .wakeupOutEn(wakeupOutEn), .lowVoltageIrq(lowVoltageIrq),
    .wakeupIrq(wakeupIrq));

  // Clock, and a slow oscillator so each level spans several bus cycles.
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    oscCnt <= oscCnt + 2'h1;
    if (oscCnt == 2'h3) autoOscRaw <= ~autoOscRaw;
  end

  // ------------------------------------------------------------
  // Bus and compare helpers; handshakes are judged before the edge.
  // ------------------------------------------------------------
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    nTests++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a;
    logic w;
    logic b;
    logic [1:0] r;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge sys_clk);
      a = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    check(r, er);
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [7:0] ed, input logic [1:0] er);
    logic a;
    logic v;
    logic [33:0] got;
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    v = 1'b0;
    while (!v) begin
      @(negedge sys_clk);
      a = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      got = {s_axi_rresp, s_axi_rdata};
      @(posedge sys_clk);
      if (a) s_axi_arvalid <= 1'b0;
    end
    check(got, {er, 24'h000000, ed});
  endtask : rd

  // Call at a falling edge; counts falling edges until the pin shows the level.
  // The bound keeps a dead output from hanging the run.
  task automatic wait_level(input logic lvl, output int n);
    n = 0;
    while (wakeupOut !== lvl && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_level

  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  task automatic t_reset_map;
    rd(rlw_pkg::IDX_TRIM, 8'h00, rlw_pkg::RESP_OKAY);
    rd(rlw_pkg::IDX_APIC, 8'h00, rlw_pkg::RESP_OKAY);
    rd(rlw_pkg::IDX_RATE_LO, 8'h00, rlw_pkg::RESP_OKAY);
    rd(10'h2f6, 8'h00, rlw_pkg::RESP_SLVERR);
    wr(10'h2f6, 8'hff, rlw_pkg::RESP_SLVERR);
    wr(rlw_pkg::IDX_TRIM, 8'hff, rlw_pkg::RESP_OKAY);
    rd(rlw_pkg::IDX_TRIM, 8'hfc, rlw_pkg::RESP_OKAY);
    check(periodTrim, 6'h3f);
  endtask : t_reset_map

  task automatic t_low_voltage;
    supplyLowRaw <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(rlw_pkg::IDX_LV_CTRL, 8'h05, rlw_pkg::RESP_OKAY);
    check(lowVoltageIrq, 1'b0);
    wr(rlw_pkg::IDX_LV_CTRL, 8'h02, rlw_pkg::RESP_OKAY);
    rd(rlw_pkg::IDX_LV_CTRL, 8'h07, rlw_pkg::RESP_OKAY);
    check(lowVoltageIrq, 1'b1);
    wr(rlw_pkg::IDX_LV_CTRL, 8'h03, rlw_pkg::RESP_OKAY);
    rd(rlw_pkg::IDX_LV_CTRL, 8'h06, rlw_pkg::RESP_OKAY);
    check(lowVoltageIrq, 1'b0);
    fullPerfRaw <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rd(rlw_pkg::IDX_LV_CTRL, 8'h03, rlw_pkg::RESP_OKAY);
    wr(rlw_pkg::IDX_LV_CTRL, 8'h01, rlw_pkg::RESP_OKAY);
    rd(rlw_pkg::IDX_LV_CTRL, 8'h00, rlw_pkg::RESP_OKAY);
  endtask : t_low_voltage

  task automatic t_bus_clock_timer;
    int n;
    wr(rlw_pkg::IDX_APIC, 8'h84, rlw_pkg::RESP_OKAY);
    rd(rlw_pkg::IDX_APIC, 8'h04, rlw_pkg::RESP_OKAY);
    // The write that stops the timer still finds it running, so clock select holds.
    wr(rlw_pkg::IDX_APIC, 8'h80, rlw_pkg::RESP_OKAY);
    rd(rlw_pkg::IDX_APIC, 8'h00, rlw_pkg::RESP_OKAY);
    wr(rlw_pkg::IDX_APIC, 8'h80, rlw_pkg::RESP_OKAY);
    rd(rlw_pkg::IDX_APIC, 8'h80, rlw_pkg::RESP_OKAY);
    wr(rlw_pkg::IDX_RATE_HI, 8'h00, rlw_pkg::RESP_OKAY);
    wr(rlw_pkg::IDX_RATE_LO, 8'h02, rlw_pkg::RESP_OKAY);
    wr(rlw_pkg::IDX_APIC, 8'h9e, rlw_pkg::RESP_OKAY);
    @(negedge sys_clk);
    check(wakeupOutEn, 1'b1);
    @(posedge sys_clk);
    wr(rlw_pkg::IDX_RATE_LO, 8'h05, rlw_pkg::RESP_OKAY);
    rd(rlw_pkg::IDX_RATE_LO, 8'h02, rlw_pkg::RESP_OKAY);
    @(negedge sys_clk);
    wait_level(1'b0, n);
    wait_level(1'b1, n);
    wait_level(1'b0, n);
    check(n, 34'd6);
    check(wakeupIrq, 1'b1);
    @(posedge sys_clk);
    wr(rlw_pkg::IDX_APIC, 8'h9b, rlw_pkg::RESP_OKAY);
    rd(rlw_pkg::IDX_APIC, 8'h9a, rlw_pkg::RESP_OKAY);
    check({wakeupOutEn, wakeupIrq}, 2'h0);
    // Shortest bus clock period in pulse mode: one cycle high every two.
    wr(rlw_pkg::IDX_RATE_LO, 8'h00, rlw_pkg::RESP_OKAY);
    wr(rlw_pkg::IDX_APIC, 8'h8c, rlw_pkg::RESP_OKAY);
    @(negedge sys_clk);
    wait_level(1'b1, n);
    wait_level(1'b0, n);
    check(n, 34'd1);
    @(posedge sys_clk);
    rd(rlw_pkg::IDX_APIC, 8'h8d, rlw_pkg::RESP_OKAY);
  endtask : t_bus_clock_timer

  task automatic t_osc_timer;
    int n;
    // The second write finds the timer stopped, so clock select and the clear both land.
    wr(rlw_pkg::IDX_APIC, 8'h00, rlw_pkg::RESP_OKAY);
    wr(rlw_pkg::IDX_APIC, 8'h01, rlw_pkg::RESP_OKAY);
    wr(rlw_pkg::IDX_RATE_LO, 8'h00, rlw_pkg::RESP_OKAY);
    wr(rlw_pkg::IDX_APIC, 8'h06, rlw_pkg::RESP_OKAY);
    repeat (8) @(negedge sys_clk);
    check(wakeupIrq, 1'b0);
    n = 0;
    while (wakeupIrq !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    check(wakeupIrq, 1'b1);
    @(posedge sys_clk);
    rd(rlw_pkg::IDX_APIC, 8'h07, rlw_pkg::RESP_OKAY);
  endtask : t_osc_timer

  task automatic printVerdict;
    $display("errors=%0d checks=%0d", errorCnt, nTests);
    if (errorCnt == 0 && nTests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : printVerdict

  // Main sequence; the watchdog is far beyond the expected run length.
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset_map();
    t_low_voltage();
    t_bus_clock_timer();
    t_osc_timer();
    printVerdict();
  end
  initial begin
    #100000;
    errorCnt++;
    printVerdict();
  end
endmodule : rlw_regulator_lvd_periodic_wakeup_bench
